// ---- fir_host_pkg.sv ----
// Overview of operation
// - coefficient of tap k*L+p at base+p*(N/L)+k
// - tap length minus one, bit 7 zero
// - taps-per-phase minus one in bits 3-0
// - coefficients are 16-bit two's complement
// - history not reset, software zeroes it
// - reserved bits and registers written zero
// - scaled absolute coefficient sum below one; code only flags a larger sum in gain_warn
// - taps-per-phase kept at 16 or less
// - factor 1 to 128, divides tap length
// - tap length within compute and memory limits
package fir_host_pkg;
    // ==========================================
    // device channel addresses
    localparam logic [7:0] DEV_TAP_LEN = 8'h0A;
    localparam logic [7:0] DEV_BASE = 8'h0B;
    localparam logic [7:0] DEV_TPP = 8'h0C;
    localparam logic [7:0] DEV_SCALE = 8'h0D;
    localparam logic [7:0] DEV_RSV_A = 8'h10;
    localparam logic [7:0] DEV_RSV_B = 8'h11;
    localparam logic [7:0] DEV_HIST = 8'h20;
    localparam logic [7:0] DEV_COEF = 8'h80;
    localparam logic [4:0] HIST_LAST = 5'h1F;
    localparam logic [4:0] CFG_LAST = 5'h05;
    // ==========================================
    // apb register offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_FILTER = 8'h04;
    localparam logic [7:0] A_BASE = 8'h08;
    localparam logic [7:0] A_SCALE = 8'h0C;
    localparam logic [7:0] A_COEF = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    // ctrl bit positions
    localparam int C_GO_CFG = 0;
    localparam int C_GO_CLR = 1;
    localparam int C_RESTART = 2;
    localparam int C_CLR_ERR = 3;
    // reset values and thresholds
    localparam logic [6:0] RST_FIELD7 = 7'h00;
    localparam logic [3:0] RST_TPP = 4'h0;
    localparam logic [22:0] GAIN_ONE = 23'h008000;
    // ==========================================
    // device request carrier
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [15:0] wdata;
    } dev_cmd_s;
    typedef enum logic [1:0] {S_IDLE, S_CFG, S_CLR, S_COEF} seq_e;
endpackage

// ---- fir_host.sv ----
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module fir_host (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device channel register port
    output fir_host_pkg::dev_cmd_s dev_cmd,
    output logic dev_req,
    input wire logic dev_ack
);
    import fir_host_pkg::*;

    // ==========================================
    // helpers
    function automatic logic [6:0] coef_off(input logic [6:0] b, input logic [6:0] p,
                                            input logic [3:0] t, input logic [3:0] k);
        logic [11:0] s;
        s = 12'(b) + 12'(p) * (12'(t) + 12'h001) + 12'(k);
        return s[6:0];
    endfunction

    function automatic logic [15:0] abs16(input logic [15:0] v);
        return v[15] ? 16'(~v + 16'h0001) : v;
    endfunction

    // ==========================================
    // state
    seq_e state_q;
    logic [4:0] step_q;
    logic [6:0] tap_m1_q, interp_m1_q, base_q, p_q;
    logic [3:0] tpp_m1_q, k_q;
    logic [1:0] scale_q;
    logic [4:0] div_q;
    logic [7:0] cnt_q;
    logic [22:0] sum_q;
    logic [15:0] coef_q;
    logic cfg_err_q, coef_err_q, cfg_valid_q;
    dev_cmd_s cmd_q;
    logic req_q;

    // ==========================================
    // apb decode
    logic busy, acc, mapped, wr_ok, cfg_ok, go_cfg, go_clr, coef_wr, coef_ok, gain_warn;
    logic clr_err, last_ack, ack;
    logic [12:0] prod;

    assign busy = (state_q != S_IDLE);
    assign acc = psel & penable;
    assign mapped = (paddr == A_CTRL) | (paddr == A_FILTER) | (paddr == A_BASE) |
                    (paddr == A_SCALE) | (paddr == A_COEF) | (paddr == A_STATUS);
    assign pready = !(busy & psel & pwrite);
    assign pslverr = acc & !mapped;
    assign wr_ok = acc & pwrite & pready & mapped;
    assign prod = (13'(tpp_m1_q) + 13'h0001) * (13'(interp_m1_q) + 13'h0001);
    // taps-per-phase times factor must equal tap length
    assign cfg_ok = (prod == 13'(tap_m1_q) + 13'h0001);
    assign go_cfg = wr_ok & (paddr == A_CTRL) & pwdata[C_GO_CFG];
    assign go_clr = wr_ok & (paddr == A_CTRL) & pwdata[C_GO_CLR] & !pwdata[C_GO_CFG];
    assign clr_err = wr_ok & (paddr == A_CTRL) & pwdata[C_CLR_ERR];
    assign coef_wr = wr_ok & (paddr == A_COEF);
    assign coef_ok = cfg_valid_q & (cnt_q <= 8'(tap_m1_q));
    // scaled absolute sum at or above one risks wrap
    assign gain_warn = ((sum_q >> scale_q) >= GAIN_ONE);
    assign ack = req_q & dev_ack;
    assign last_ack = ack & (((state_q == S_CFG) & (step_q == CFG_LAST)) |
                             ((state_q == S_CLR) & (step_q == HIST_LAST)) |
                             (state_q == S_COEF));

    always_comb begin
        prdata = 32'h00000000;
        unique case (paddr)
            A_FILTER: prdata = {12'h000, tpp_m1_q, 1'b0, interp_m1_q, 1'b0, tap_m1_q};
            A_BASE: prdata = {25'h0000000, base_q};
            A_SCALE: prdata = {19'h00000, div_q, 6'h00, scale_q};
            A_STATUS: prdata = {16'h0000, cnt_q, 3'h0, cfg_valid_q, gain_warn,
                                coef_err_q, cfg_err_q, busy};
            default: prdata = 32'h00000000;
        endcase
    end

    // ==========================================
    // software settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap_m1_q <= RST_FIELD7;
            interp_m1_q <= RST_FIELD7;
            tpp_m1_q <= RST_TPP;
            base_q <= RST_FIELD7;
            scale_q <= 2'h0;
            div_q <= 5'h00;
        end else if (wr_ok) begin
            if (paddr == A_FILTER) begin
                tap_m1_q <= pwdata[6:0];
                interp_m1_q <= pwdata[14:8];
                tpp_m1_q <= pwdata[19:16];
            end
            if (paddr == A_BASE) begin
                base_q <= pwdata[6:0];
            end
            if (paddr == A_SCALE) begin
                scale_q <= pwdata[1:0];
                div_q <= pwdata[12:8];
            end
        end
    end

    // ==========================================
    // error and validity flags, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_err_q <= 1'b0;
            coef_err_q <= 1'b0;
            cfg_valid_q <= 1'b0;
        end else begin
            if (go_cfg & !cfg_ok) begin
                cfg_err_q <= 1'b1;
            end else if (clr_err) begin
                cfg_err_q <= 1'b0;
            end
            if (coef_wr & !coef_ok) begin
                coef_err_q <= 1'b1;
            end else if (clr_err) begin
                coef_err_q <= 1'b0;
            end
            if (go_cfg) begin
                cfg_valid_q <= cfg_ok;
            end else if (wr_ok & (paddr == A_FILTER)) begin
                cfg_valid_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // coefficient reorder counters, natural tap order in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            k_q <= 4'h0;
            p_q <= 7'h00;
            cnt_q <= 8'h00;
            sum_q <= 23'h000000;
            coef_q <= 16'h0000;
        end else if (go_cfg | (wr_ok & (paddr == A_CTRL) & pwdata[C_RESTART])) begin
            k_q <= 4'h0;
            p_q <= 7'h00;
            cnt_q <= 8'h00;
            sum_q <= 23'h000000;
        end else if (coef_wr & coef_ok) begin
            coef_q <= pwdata[15:0];
            cnt_q <= cnt_q + 8'h01;
            sum_q <= sum_q + 23'(abs16(pwdata[15:0]));
            if (p_q == interp_m1_q) begin
                p_q <= 7'h00;
                k_q <= k_q + 4'h1;
            end else begin
                p_q <= p_q + 7'h01;
            end
        end
    end

    // ==========================================
    // device write sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            step_q <= 5'h00;
            req_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (go_cfg & cfg_ok) begin
                        state_q <= S_CFG;
                        step_q <= 5'h00;
                        req_q <= 1'b1;
                        // tap length minus one, bit 7 zero
                        cmd_q <= '{1'b1, DEV_TAP_LEN, {9'h000, tap_m1_q}};
                    end else if (go_clr) begin
                        state_q <= S_CLR;
                        step_q <= 5'h00;
                        req_q <= 1'b1;
                        // zero the history before running
                        cmd_q <= '{1'b1, DEV_HIST, 16'h0000};
                    end else if (coef_wr & coef_ok) begin
                        state_q <= S_COEF;
                        req_q <= 1'b1;
                        // phase-major placement value unchanged
                        cmd_q <= '{1'b1, DEV_COEF | {1'b0, coef_off(base_q, p_q, tpp_m1_q,
                                   k_q)}, pwdata[15:0]};
                    end
                end
                S_CFG: begin
                    if (last_ack) begin
                        state_q <= S_IDLE;
                        req_q <= 1'b0;
                    end else if (ack) begin
                        step_q <= step_q + 5'h01;
                        unique case (step_q)
                            5'h00: cmd_q <= '{1'b1, DEV_BASE, {9'h000, base_q}};
                            // taps-per-phase minus one
                            5'h01: cmd_q <= '{1'b1, DEV_TPP, {12'h000, tpp_m1_q}};
                            // reserved bit 5 zero
                            5'h02: cmd_q <= '{1'b1, DEV_SCALE, {8'h00, scale_q, 1'b0, div_q}};
                            // reserved registers written zero
                            5'h03: cmd_q <= '{1'b1, DEV_RSV_A, 16'h0000};
                            default: cmd_q <= '{1'b1, DEV_RSV_B, 16'h0000};
                        endcase
                    end
                end
                S_CLR: begin
                    if (last_ack) begin
                        state_q <= S_IDLE;
                        req_q <= 1'b0;
                    end else if (ack) begin
                        step_q <= step_q + 5'h01;
                        cmd_q <= '{1'b1, DEV_HIST | {3'h0, step_q + 5'h01}, 16'h0000};
                    end
                end
                S_COEF: begin
                    if (ack) begin
                        state_q <= S_IDLE;
                        req_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign dev_req = req_q;
    assign dev_cmd = cmd_q;

    // ==========================================
    // checks
    sequence s_cfg_go;
        go_cfg && cfg_ok && !busy;
    endsequence
    sequence s_cfg_first;
        dev_req && dev_cmd.addr == DEV_TAP_LEN && state_q == S_CFG;
    endsequence
    sequence s_clr_go;
        go_clr && !busy;
    endsequence
    sequence s_clr_first;
        dev_req && dev_cmd.addr == DEV_HIST && state_q == S_CLR;
    endsequence

    cfg_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_cfg_go |=> s_cfg_first) else $error("config did not start with tap length");
    tap_field_a: assert property (@(posedge pclk) disable iff (!presetn)
        dev_req && dev_cmd.addr == DEV_TAP_LEN |-> dev_cmd.wdata[15:7] == 9'h000)
        else $error("tap length word has upper bits set");
    tpp_field_a: assert property (@(posedge pclk) disable iff (!presetn)
        dev_req && dev_cmd.addr == DEV_TPP |-> dev_cmd.wdata == {12'h000, tpp_m1_q})
        else $error("taps per phase word wrong");
    scale_rsv_a: assert property (@(posedge pclk) disable iff (!presetn)
        dev_req && dev_cmd.addr == DEV_SCALE |-> dev_cmd.wdata[15:5] == {8'h00, scale_q, 1'b0})
        else $error("scale word reserved bits wrong");
    rsv_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        dev_req && (dev_cmd.addr == DEV_RSV_A || dev_cmd.addr == DEV_RSV_B)
        |-> dev_cmd.wdata == 16'h0000) else $error("reserved register not zero");
    hist_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        dev_req && dev_cmd.addr[7:5] == 3'h1 |-> dev_cmd.we && dev_cmd.wdata == 16'h0000)
        else $error("history written nonzero");
    clr_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == S_CLR && ack && step_q == HIST_LAST |=> !dev_req && !busy)
        else $error("history clear did not end after 32 words");
    req_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        dev_req && !dev_ack |=> dev_req && $stable(dev_cmd))
        else $error("device request dropped before ack");
    bad_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
        go_cfg && !cfg_ok |=> !busy && cfg_err_q && !cfg_valid_q)
        else $error("bad configuration was accepted");
    coef_place_a: assert property (@(posedge pclk) disable iff (!presetn)
        coef_wr && coef_ok && !busy |=> dev_req && dev_cmd.addr[7] &&
        dev_cmd.addr[6:0] == coef_off(base_q, $past(p_q), tpp_m1_q, $past(k_q)) &&
        dev_cmd.wdata == coef_q) else $error("coefficient misplaced");
    clr_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_clr_go |=> s_clr_first) else $error("history clear did not start at first word");
    clr_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == S_CLR && ack && step_q != HIST_LAST |=> dev_req &&
        dev_cmd.addr[7:5] == 3'h1 && dev_cmd.addr[4:0] == $past(step_q) + 5'h01)
        else $error("history clear skipped a word");
    cfg_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == S_CFG && ack && step_q == 5'h01 |=> dev_req && dev_cmd.addr == DEV_TPP)
        else $error("taps per phase not third in config");
    cfg_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == S_CFG && ack && step_q == CFG_LAST |=> !dev_req && !busy)
        else $error("config did not end after reserved words");
    base_word_a: assert property (@(posedge pclk) disable iff (!presetn)
        dev_req && dev_cmd.addr == DEV_BASE |-> dev_cmd.wdata == {9'h000, base_q})
        else $error("base pointer word wrong");
    coef_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
        coef_wr && !coef_ok |=> coef_err_q && !dev_req)
        else $error("refused coefficient was sent");
    restart_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ok && paddr == A_CTRL && pwdata[C_RESTART] |=> cnt_q == 8'h00)
        else $error("coefficient count not restarted");
endmodule

// ---- fir_dev_model.sv ----
`timescale 1ns/1ps
module fir_dev_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // channel register port
    input wire fir_host_pkg::dev_cmd_s dev_cmd,
    input wire logic dev_req,
    output logic dev_ack
);
    import fir_host_pkg::*;
    logic [15:0] regs [0:31];
    logic [15:0] hist [0:31];
    logic [15:0] coefficient_memory [0:127];
    logic [1:0] wait_q;
    logic [1:0] slow_q;
    // ==========================================
    // power-up contents, kept across reset
    initial begin
        for (int i = 0; i < 32; i++) begin
            regs[i] = 16'hFFFF;
            hist[i] = 16'hA5A5;
        end
        for (int i = 0; i < 128; i++) coefficient_memory[i] = 16'h5A5A;
    end
    // ==========================================
    // one channel's filter: serial word in, one output per phase for each 16-bit half
    int head = 0;
    task automatic push(input logic [31:0] word);
        head = (head + 1) % 16;
        hist[2 * head] = word[31:16];
        hist[2 * head + 1] = word[15:0];
    endtask
    function automatic int fir_out(input int p, input int part);
        int acc;
        int tpp;
        acc = 0;
        tpp = regs[5'h0C][3:0] + 1;
        for (int k = 0; k < tpp; k++) begin
            acc += $signed(coefficient_memory[7'(regs[5'h0B][6:0] + p * tpp + k)]) *
                   $signed(hist[2 * ((head - k + 16) % 16) + part]);
        end
        return acc >>> regs[5'h0D][7:6];
    endfunction
    // ==========================================
    // write capture, ack delay cycles 0..3
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_ack <= 1'b0;
            wait_q <= 2'h0;
            slow_q <= 2'h0;
        end else if (dev_ack) begin
            dev_ack <= 1'b0;
            slow_q <= slow_q + 2'h1;
            if (dev_cmd.we && dev_cmd.addr[7]) begin
                coefficient_memory[dev_cmd.addr[6:0]] <= dev_cmd.wdata;
            end else if (dev_cmd.we && dev_cmd.addr[7:5] == 3'h1) begin
                hist[dev_cmd.addr[4:0]] <= dev_cmd.wdata;
            end else if (dev_cmd.we && dev_cmd.addr[7:5] == 3'h0) begin
                regs[dev_cmd.addr[4:0]] <= dev_cmd.wdata;
            end
        end else if (dev_req) begin
            if (wait_q == slow_q) begin
                dev_ack <= 1'b1;
                wait_q <= 2'h0;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule

// ---- fir_host_tb.sv ----
`timescale 1ns/1ps
module fir_host_tb;
    import fir_host_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dev_req;
    logic dev_ack;
    dev_cmd_s dev_cmd;
    logic [31:0] rd;
    logic er;
    logic [6:0] base;
    int errors = 0;
    int n_tests = 0;
    logic [15:0] cfg_exp [6] = '{16'h0007, 16'h0005, 16'h0003, 16'h0093, 16'h0000, 16'h0000};
    logic [4:0] cfg_idx [6] = '{5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h10, 5'h11};
    always #2.5 pclk = ~pclk;
    fir_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dev_cmd(dev_cmd), .dev_req(dev_req), .dev_ack(dev_ack));
    fir_dev_model u_dev (.pclk(pclk), .presetn(presetn), .dev_cmd(dev_cmd),
        .dev_req(dev_req), .dev_ack(dev_ack));
    // ==========================================
    // shared tasks
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        bit done;
        done = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 400 && !done; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                rd = prdata;
                er = pslverr;
                done = 1;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (!done) begin errors++; wrap_up(); end
    endtask
    task automatic idle_wait;
        int n;
        for (n = 0; n < 300; n++) begin
            apb(1'b0, A_STATUS, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        if (n == 300) begin errors++; wrap_up(); end
    endtask
    function automatic logic [15:0] hv(input int r, input int n);
        return (r != 0 ? 16'h9000 : 16'h1000) + 16'(n);
    endfunction
    // ==========================================
    // main sequence
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, A_STATUS, 32'h0);
        chk("status after reset", 32'h0, rd);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        apb(1'b1, A_CTRL, 32'h2);
        apb(1'b1, A_BASE, 32'h5);
        apb(1'b0, A_STATUS, 32'h0);
        chk("busy after stall", 32'h0, {31'h0, rd[0]});
        apb(1'b0, A_BASE, 32'h0);
        chk("base readback", 32'h5, rd);
        for (int i = 0; i < 32; i++) chk("history", 32'h0, {16'h0, u_dev.hist[i]});
        apb(1'b1, A_FILTER, 32'h0003_0107);
        apb(1'b0, A_FILTER, 32'h0);
        chk("filter readback", 32'h0003_0107, rd);
        for (int g = 0; g < 4; g++) begin
            apb(1'b1, A_SCALE, 32'h1300 | 32'(g));
            apb(1'b1, A_CTRL, 32'h1);
            idle_wait();
            chk("scale reg", 32'h13 | 32'(g << 6), {16'h0, u_dev.regs[5'h0D]});
        end
        apb(1'b1, A_SCALE, 32'h1302);
        apb(1'b0, A_SCALE, 32'h0);
        chk("scale readback", 32'h1302, rd);
        for (int r = 0; r < 2; r++) begin
            base = r != 0 ? 7'h7E : 7'h05;
            apb(1'b1, A_BASE, {25'h0, base});
            apb(1'b1, A_CTRL, 32'h1);
            idle_wait();
            chk("dev base", {25'h0, base}, {16'h0, u_dev.regs[5'h0B]});
            if (r == 0) begin
                for (int i = 0; i < 6; i++) chk("dev cfg", {16'h0, cfg_exp[i]}, {16'h0, u_dev.regs[cfg_idx[i]]});
            end
            for (int n = 0; n < 8; n++) apb(1'b1, A_COEF, {16'h0, hv(r, n)});
            idle_wait();
            chk("status coef", r != 0 ? 32'h0818 : 32'h0810, rd);
            for (int p = 0; p < 2; p++) begin
                for (int k = 0; k < 4; k++) chk("coef store", {16'h0, hv(r, k * 2 + p)}, {16'h0, u_dev.coefficient_memory[7'(base + p * 4 + k)]});
            end
            if (r == 0) begin
                u_dev.push(32'h0004_FFFC);
                for (int p = 0; p < 2; p++) begin
                    chk("fir out i", {16'h0, hv(0, p)}, 32'(u_dev.fir_out(p, 0)));
                    chk("fir out q", -{16'h0, hv(0, p)}, 32'(u_dev.fir_out(p, 1)));
                end
                u_dev.push(32'h0);
                for (int p = 0; p < 2; p++) begin
                    chk("fir out older", {16'h0, hv(0, p + 2)}, 32'(u_dev.fir_out(p, 0)));
                end
            end
            apb(1'b1, A_COEF, 32'h7777);
            apb(1'b0, A_STATUS, 32'h0);
            chk("coef overflow", r != 0 ? 32'h081C : 32'h0814, rd);
            apb(1'b1, A_CTRL, 32'h8);
            apb(1'b0, A_STATUS, 32'h0);
            chk("error clear", r != 0 ? 32'h0818 : 32'h0810, rd);
            apb(1'b1, A_CTRL, 32'h4);
            apb(1'b0, A_STATUS, 32'h0);
            chk("restart", 32'h0010, rd);
        end
        apb(1'b1, A_FILTER, 32'h0001_0209);
        apb(1'b1, A_CTRL, 32'h1);
        idle_wait();
        chk("bad config", 32'h02, rd & 32'h13);
        chk("no config sent", 32'h7, {16'h0, u_dev.regs[5'h0A]});
        apb(1'b1, A_COEF, 32'h1);
        apb(1'b0, A_STATUS, 32'h0);
        chk("coef refused", 32'h06, rd & 32'h17);
        wrap_up();
    end
endmodule
